/* verilog/csr_bank_pkg.sv */
package csr_bank_pkg;
   localparam int DATA_W = 16;
   localparam int IDX_W = 2;
   localparam logic [1:0] IDX_COMMAND = 2'h0;
   localparam logic [1:0] IDX_PTR_LOW = 2'h1;
   localparam logic [1:0] IDX_PTR_HIGH = 2'h2;
   localparam logic [1:0] IDX_OPTIONS = 2'h3;
   // Command/status bit positions
   localparam int B_ERR = 15;
   localparam int B_BABBLE = 14;
   localparam int B_COLL_ERR = 13;
   localparam int B_MISSED = 12;
   localparam int B_MEM_ERR = 11;
   localparam int B_RX_DONE = 10;
   localparam int B_TX_DONE = 9;
   localparam int B_SETUP_DONE = 8;
   localparam int B_SUMMARY = 7;
   localparam int B_INT_EN = 6;
   localparam int B_RX_ON = 5;
   localparam int B_TX_ON = 4;
   localparam int B_DEMAND = 3;
   localparam int B_HALT = 2;
   localparam int B_START = 1;
   localparam int B_SETUP = 0;
   // Option bit positions
   localparam int B_BYTE_SWAP = 2;
   localparam int B_STROBE_POL = 1;
   localparam int B_PIN_MODE = 0;
   // Mode word bit positions
   localparam int B_ACCEPT_ALL = 15;
   localparam int B_TX_DISABLE = 1;
   localparam int B_RX_DISABLE = 0;
   localparam logic [15:0] PTR_LOW_MASK = 16'hFFFE;
   localparam logic [15:0] PTR_HIGH_MASK = 16'h00FF;
   localparam logic [15:0] OPTIONS_MASK = 16'h0007;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   // Transmit ring poll interval
   localparam int POLL_TIME_US = 1600;
   localparam int CLK_MHZ = 100;
   localparam int POLL_CYCLES = POLL_TIME_US * CLK_MHZ;

   typedef struct packed {
      logic babble;
      logic coll_err;
      logic missed;
      logic mem_err;
      logic rx_done;
      logic tx_done;
      logic setup_done;
      logic tx_underflow;
      logic demand_taken;
   } events_s;

   typedef struct packed {
      logic byte_swap;
      logic strobe_pol;
      logic pin_mode;
   } options_s;

   typedef enum logic [1:0] {BUS_IDLE, BUS_HOLD} bus_state_e;
endpackage

/* verilog/ethernet_controller_csr_bank.sv */
// What this block does
// - Receive-complete flag sets when the last receive ring entry is written back.
// - Transmit-complete flag sets when the last transmit ring entry is written back.
// - Setup-done flag sets only after the parameter block is fully loaded.
// - Completion flags: hardware sets, write one clears, reset or halt clears.
// - Summary flag is OR of six event flags, read only, cleared by halt.
// - Interrupt pin low, one clock later, exactly when enable and summary flag are both one.
// - Interrupt enable is plain read/write, cleared by reset or halt.
// - Receiver-on sets with setup-done unless disabled; reads zero until start.
// - Transmitter-on sets with setup-done unless disabled; underflow clears it.
// - Transmit demand forces an immediate ring scan, self-clears when taken.
// - Halt clears all but host port state, the pointer registers and the accept-all latch; set by reset; held until start/setup.
// - Start, setup and halt written together leave only halt set.
// - Start enables traffic and mastering; write-one only; halt clears it.
// - Setup begins parameter fetch, runs before start; write-one only.
// - Pointer and option registers reachable only while halted; ready still given.
// - Pointer low holds address bits 15:1, bit 0 zero, kept through reset.
// - Pointer high holds address bits 23:16 in bits 7:0, kept through reset.
// - Option register cleared by reset or halt; bits 15:3 read zero.
// - Byte swap applies to packet buffer transfers only.
// - Strobe polarity option picks high latch enable or low address strobe.
// - Pin mode option redefines byte mask and hold pins.
// - Accept-all bit of the mode word accepts every destination address.
// - Host writes an index to the index port, then uses the data port.
module ethernet_controller_csr_bank
   import csr_bank_pkg::*;
#(
   parameter int POLL_CYC = POLL_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic cs_n,
   input wire logic read_sel,
   input wire logic das_n,
   input wire logic port_sel,
   input wire logic [DATA_W-1:0] dal_in,
   output logic [DATA_W-1:0] dal_out,
   output logic dal_oe_n,
   output logic ready_n,
   output logic summary_interrupt_flag_n,
   input wire events_s evt,
   input wire logic [DATA_W-1:0] mode_word,
   input wire logic [DATA_W-1:0] mem_word_in,
   input wire logic mem_word_is_fifo,
   output logic [DATA_W-1:0] mem_word_out,
   input wire logic strobe_req,
   input wire logic upper_byte_mask,
   input wire logic lower_byte_mask,
   input wire logic hold_req,
   input wire logic grant_chain_output,
   input wire logic byte_sel,
   input wire logic bus_request_pin,
   output logic address_strobe_pin,
   output logic [2:0] redefined_pins,
   output logic [23:0] param_block_pointer,
   output options_s options,
   output logic setup_req,
   output logic run_enable,
   output logic rx_enable,
   output logic tx_enable,
   output logic scan_ring,
   output logic accept_all_addresses_bit,
   output logic halted
);

   function automatic logic [DATA_W-1:0] swap_bytes(input logic [DATA_W-1:0] w);
      swap_bytes = {w[7:0], w[15:8]};
   endfunction

   // Host pins come from another domain
   logic [3:0] pin_meta_ff, pin_sync_ff;
   logic [DATA_W-1:0] dal_meta_ff, dal_sync_ff;
   always_ff @(posedge mclk) begin
      pin_meta_ff <= {cs_n, read_sel, das_n, port_sel};
      pin_sync_ff <= pin_meta_ff;
      dal_meta_ff <= dal_in;
      dal_sync_ff <= dal_meta_ff;
   end
   wire cs_s = ~pin_sync_ff[3];
   wire rd_s = pin_sync_ff[2];
   wire das_s = ~pin_sync_ff[1];
   wire adr_s = pin_sync_ff[0];

   bus_state_e bus_ff, nxt_bus;
   logic [IDX_W-1:0] index_port_ff;
   logic babble_ff, coll_ff, missed_ff, memory_error_flag_ff, rx_done_ff, tx_done_ff, setup_done_ff;
   logic int_en_ff, rx_on_ff, tx_on_ff, demand_ff, halt_ff, start_ff, setup_ff;
   logic [DATA_W-1:0] ptr_low_ff, ptr_high_ff;
   options_s opt_ff;
   logic [DATA_W-1:0] dal_out_ff;
   logic dal_oe_n_ff, ready_n_ff, summary_interrupt_flag_n_ff;
   logic [31:0] poll_cnt_ff;

   // Bus transaction decode
   wire access_go = (bus_ff == BUS_IDLE) && cs_s && das_s;
   wire access_end = (bus_ff == BUS_HOLD) && !(cs_s && das_s);
   wire index_wr = access_go && !rd_s && adr_s;
   wire data_wr = access_go && !rd_s && !adr_s;
   wire data_rd = access_go && rd_s && !adr_s;
   wire index_rd = access_go && rd_s && adr_s;
   wire locked = (index_port_ff != IDX_COMMAND) && !halt_ff;
   wire cmd_wr = data_wr && (index_port_ff == IDX_COMMAND);
   wire low_wr = data_wr && !locked && (index_port_ff == IDX_PTR_LOW);
   wire high_wr = data_wr && !locked && (index_port_ff == IDX_PTR_HIGH);
   wire opt_wr = data_wr && !locked && (index_port_ff == IDX_OPTIONS);
   wire [DATA_W-1:0] wd = dal_sync_ff;

   wire halt_cmd = cmd_wr && wd[B_HALT];
   wire go_cmd = cmd_wr && !wd[B_HALT] && (wd[B_START] || wd[B_SETUP]);
   wire clr_all = !resetn || halt_cmd;

   wire summary = babble_ff | missed_ff | memory_error_flag_ff | rx_done_ff | tx_done_ff
      | setup_done_ff;
   wire err_sum = babble_ff | coll_ff | missed_ff | memory_error_flag_ff;

   wire [DATA_W-1:0] cmd_word = {err_sum, babble_ff, coll_ff, missed_ff, memory_error_flag_ff,
      rx_done_ff, tx_done_ff, setup_done_ff, summary, int_en_ff,
      rx_on_ff & start_ff, tx_on_ff & start_ff,
      demand_ff, halt_ff, start_ff, setup_ff};
   wire [DATA_W-1:0] opt_word = {13'h0000, opt_ff.byte_swap, opt_ff.strobe_pol,
      opt_ff.pin_mode} & OPTIONS_MASK;

   logic [DATA_W-1:0] rd_word;
   always_comb begin
      case (index_port_ff)
         IDX_COMMAND: rd_word = cmd_word;
         IDX_PTR_LOW: rd_word = ptr_low_ff & PTR_LOW_MASK;
         IDX_PTR_HIGH: rd_word = ptr_high_ff & PTR_HIGH_MASK;
         default: rd_word = opt_word;
      endcase
   end

   always_comb begin
      case (bus_ff)
         BUS_IDLE: nxt_bus = access_go ? BUS_HOLD : BUS_IDLE;
         BUS_HOLD: nxt_bus = access_end ? BUS_IDLE : BUS_HOLD;
         default: nxt_bus = BUS_IDLE;
      endcase
   end

   // Host port: ready held until the host drops its strobe
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         bus_ff <= BUS_IDLE;
         index_port_ff <= IDX_COMMAND;
         ready_n_ff <= 1'b1;
         dal_oe_n_ff <= 1'b1;
         dal_out_ff <= ZERO_WORD;
      end else begin
         bus_ff <= nxt_bus;
         if (index_wr)
            index_port_ff <= wd[IDX_W-1:0];
         if (access_go)
            ready_n_ff <= 1'b0;
         else if (access_end)
            ready_n_ff <= 1'b1;
         if (index_rd) begin
            dal_out_ff <= {14'h0000, index_port_ff};
            dal_oe_n_ff <= 1'b0;
         end else if (data_rd && !locked) begin
            dal_out_ff <= rd_word;
            dal_oe_n_ff <= 1'b0;
         end else if (access_end) begin
            dal_oe_n_ff <= 1'b1;
         end
      end
   end

   // Completion and error flags: a new event beats a same-cycle write-one clear
   function automatic logic flag_next(input logic cur, input logic set, input logic clr);
      flag_next = set | (cur & ~clr);
   endfunction

   always_ff @(posedge mclk) begin
      if (clr_all) begin
         babble_ff <= 1'b0;
         coll_ff <= 1'b0;
         missed_ff <= 1'b0;
         memory_error_flag_ff <= 1'b0;
         rx_done_ff <= 1'b0;
         tx_done_ff <= 1'b0;
         setup_done_ff <= 1'b0;
      end else begin
         babble_ff <= flag_next(babble_ff, evt.babble, cmd_wr && wd[B_BABBLE]);
         coll_ff <= flag_next(coll_ff, evt.coll_err, cmd_wr && wd[B_COLL_ERR]);
         missed_ff <= flag_next(missed_ff, evt.missed, cmd_wr && wd[B_MISSED]);
         memory_error_flag_ff <= flag_next(memory_error_flag_ff, evt.mem_err, cmd_wr && wd[B_MEM_ERR]);
         rx_done_ff <= flag_next(rx_done_ff, evt.rx_done, cmd_wr && wd[B_RX_DONE]);
         tx_done_ff <= flag_next(tx_done_ff, evt.tx_done, cmd_wr && wd[B_TX_DONE]);
         setup_done_ff <= flag_next(setup_done_ff, evt.setup_done && setup_ff,
            cmd_wr && wd[B_SETUP_DONE]);
      end
   end

   // Commands and engine status
   always_ff @(posedge mclk) begin
      if (clr_all) begin
         int_en_ff <= 1'b0;
         rx_on_ff <= 1'b0;
         tx_on_ff <= 1'b0;
         demand_ff <= 1'b0;
         halt_ff <= 1'b1;
         start_ff <= 1'b0;
         setup_ff <= 1'b0;
         opt_ff <= '0;
      end else begin
         if (cmd_wr)
            int_en_ff <= wd[B_INT_EN];
         if (evt.mem_err)
            rx_on_ff <= 1'b0;
         else if (evt.setup_done && setup_ff && !mode_word[B_RX_DISABLE])
            rx_on_ff <= 1'b1;
         if (evt.mem_err || evt.tx_underflow)
            tx_on_ff <= 1'b0;
         else if (evt.setup_done && setup_ff && !mode_word[B_TX_DISABLE])
            tx_on_ff <= 1'b1;
         if (cmd_wr && wd[B_DEMAND])
            demand_ff <= 1'b1;
         else if (evt.demand_taken)
            demand_ff <= 1'b0;
         if (go_cmd)
            halt_ff <= 1'b0;
         if (cmd_wr && wd[B_START])
            start_ff <= 1'b1;
         if (cmd_wr && wd[B_SETUP])
            setup_ff <= 1'b1;
         else if (evt.setup_done)
            setup_ff <= 1'b0;
         if (opt_wr)
            opt_ff <= wd[B_BYTE_SWAP:B_PIN_MODE];
      end
   end

   // Pointer words survive reset by design
   always_ff @(posedge mclk) begin
      if (low_wr)
         ptr_low_ff <= wd & PTR_LOW_MASK;
      if (high_wr)
         ptr_high_ff <= wd & PTR_HIGH_MASK;
   end

   // Ring poll timer; demand short-cuts the wait
   wire polling = start_ff && tx_on_ff && !setup_ff;
   wire poll_due = poll_cnt_ff >= 32'(POLL_CYC - 1);
   logic scan_ff, setup_req_ff, run_ff, rx_en_ff, tx_en_ff, accept_ff, halted_ff;
   always_ff @(posedge mclk) begin
      if (clr_all) begin
         poll_cnt_ff <= 32'h0000_0000;
         scan_ff <= 1'b0;
      end else begin
         scan_ff <= polling && (poll_due || (demand_ff && !scan_ff));
         if (!polling || poll_due || demand_ff)
            poll_cnt_ff <= 32'h0000_0000;
         else
            poll_cnt_ff <= poll_cnt_ff + 32'h0000_0001;
      end
   end

   // Registered control outputs; start waits for setup to finish first
   always_ff @(posedge mclk) begin
      if (clr_all) begin
         setup_req_ff <= 1'b0;
         run_ff <= 1'b0;
         rx_en_ff <= 1'b0;
         tx_en_ff <= 1'b0;
         halted_ff <= 1'b1;
         summary_interrupt_flag_n_ff <= 1'b1;
      end else begin
         setup_req_ff <= setup_ff;
         run_ff <= start_ff && !setup_ff;
         rx_en_ff <= start_ff && rx_on_ff && !evt.mem_err;
         tx_en_ff <= start_ff && tx_on_ff && !evt.mem_err && !evt.tx_underflow;
         halted_ff <= halt_ff && !go_cmd;
         summary_interrupt_flag_n_ff <= !(int_en_ff && summary);
      end
   end

   // Mode word accept-all bit latched when the parameter block completes
   always_ff @(posedge mclk) begin
      if (!resetn)
         accept_ff <= 1'b0;
      else if (evt.setup_done && setup_ff)
         accept_ff <= mode_word[B_ACCEPT_ALL];
   end

   // Master-side pin shaping; halt holds the address strobe inactive, other pins and data pass through
   logic strobe_ff;
   logic [2:0] pins_ff;
   logic [DATA_W-1:0] mem_ff;
   always_ff @(posedge mclk) begin
      if (clr_all) begin
         strobe_ff <= 1'b0;
         pins_ff <= 3'h0;
         mem_ff <= ZERO_WORD;
      end else begin
         strobe_ff <= (strobe_req && !halt_ff) ^ opt_ff.strobe_pol;
         pins_ff <= opt_ff.pin_mode
            ? {grant_chain_output, byte_sel, bus_request_pin}
            : {upper_byte_mask, lower_byte_mask, hold_req};
         mem_ff <= (mem_word_is_fifo && opt_ff.byte_swap)
            ? swap_bytes(mem_word_in) : mem_word_in;
      end
   end

   assign dal_out = dal_out_ff;
   assign dal_oe_n = dal_oe_n_ff;
   assign ready_n = ready_n_ff;
   assign summary_interrupt_flag_n = summary_interrupt_flag_n_ff;
   assign mem_word_out = mem_ff;
   assign address_strobe_pin = strobe_ff;
   assign redefined_pins = pins_ff;
   assign param_block_pointer = {ptr_high_ff[7:0], ptr_low_ff};
   assign options = opt_ff;
   assign setup_req = setup_req_ff;
   assign run_enable = run_ff;
   assign rx_enable = rx_en_ff;
   assign tx_enable = tx_en_ff;
   assign scan_ring = scan_ff;
   assign accept_all_addresses_bit = accept_ff;
   assign halted = halted_ff;

   a_rx_done_set: assert property (@(posedge mclk) disable iff (!resetn)
      evt.rx_done && !halt_cmd |=> rx_done_ff)
      else $error("receive-complete flag missed its event");
   a_tx_done_set: assert property (@(posedge mclk) disable iff (!resetn)
      evt.tx_done && !halt_cmd |=> tx_done_ff)
      else $error("transmit-complete flag missed its event");
   a_setup_done_cause: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(setup_done_ff) |-> $past(evt.setup_done) && $past(setup_ff))
      else $error("setup-done rose without a finished fetch");
   a_flag_w1c: assert property (@(posedge mclk) disable iff (!resetn)
      cmd_wr && wd[B_TX_DONE] && !evt.tx_done |=> !tx_done_ff)
      else $error("write one did not clear transmit-complete");
   a_summary_interrupt_flag_pin: assert property (@(posedge mclk) disable iff (!resetn)
      !halt_cmd |=> summary_interrupt_flag_n == !($past(int_en_ff) && $past(summary)))
      else $error("interrupt pin disagrees with enable and flag");
   a_halt_clears: assert property (@(posedge mclk) disable iff (!resetn)
      halt_cmd |=> halt_ff && !start_ff && !setup_ff && !int_en_ff && !summary)
      else $error("halt left state behind");
   a_halt_priority: assert property (@(posedge mclk) disable iff (!resetn)
      cmd_wr && wd[B_HALT] && wd[B_START] && wd[B_SETUP] |=> halt_ff && !start_ff)
      else $error("halt did not override start and setup");
   a_locked_ready: assert property (@(posedge mclk) disable iff (!resetn)
      data_rd && locked |=> !ready_n && dal_oe_n)
      else $error("locked access drove data or withheld ready");
   a_demand_scan: assert property (@(posedge mclk) disable iff (!resetn)
      polling && demand_ff && !scan_ff && !halt_cmd |=> scan_ring)
      else $error("transmit demand did not trigger a scan");
   a_rx_on_gate: assert property (@(posedge mclk) disable iff (!resetn)
      !start_ff |-> !cmd_word[B_RX_ON] && !cmd_word[B_TX_ON])
      else $error("engine status visible before start");

   // Locked accesses, write-one-only bits, latches and pin shaping
   a_locked_write: assert property (@(posedge mclk) disable iff (!resetn)
      data_wr && locked |=> $stable(ptr_low_ff) && $stable(ptr_high_ff) && $stable(opt_ff))
      else $error("locked write changed a pointer or option register");
   a_flag_w0_keeps: assert property (@(posedge mclk) disable iff (!resetn)
      cmd_wr && !wd[B_RX_DONE] && rx_done_ff && !halt_cmd |=> rx_done_ff)
      else $error("writing zero cleared receive-complete");
   a_start_w0_keeps: assert property (@(posedge mclk) disable iff (!resetn)
      cmd_wr && !wd[B_START] && start_ff && !halt_cmd |=> start_ff)
      else $error("writing zero cleared start");
   a_demand_w0: assert property (@(posedge mclk) disable iff (!resetn)
      cmd_wr && !wd[B_DEMAND] && !demand_ff && !halt_cmd |=> !demand_ff)
      else $error("writing zero raised transmit demand");
   a_accept_latch: assert property (@(posedge mclk) disable iff (!resetn)
      evt.setup_done && setup_ff |=> accept_ff == $past(mode_word[B_ACCEPT_ALL]))
      else $error("accept-all bit not taken from the mode word");
   a_swap_path: assert property (@(posedge mclk) disable iff (!resetn)
      !$past(clr_all) && $past(mem_word_is_fifo && opt_ff.byte_swap)
      |-> mem_word_out == swap_bytes($past(mem_word_in)))
      else $error("packet buffer word not byte swapped");
   a_strobe_halt: assert property (@(posedge mclk) disable iff (!resetn)
      !$past(clr_all) && $past(halt_ff)
      |-> address_strobe_pin == $past(opt_ff.strobe_pol))
      else $error("address strobe active while halted");
endmodule

/* tb/host_bus_model.sv */
module host_bus_model
   import csr_bank_pkg::*;
(
   input wire logic mclk,
   input wire logic ready_n,
   input wire logic [DATA_W-1:0] dal_out,
   input wire logic dal_oe_n,
   output logic cs_n,
   output logic read_sel,
   output logic das_n,
   output logic port_sel,
   output logic [DATA_W-1:0] dal_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n = 1'b1;
      das_n = 1'b1;
      read_sel = 1'b1;
      port_sel = 1'b1;
      dal_in = 16'h0000;
   end
   // Pins stay put until ready is seen at an edge; data line flips once let go
   task automatic access(input logic sel, input logic rdn, input logic [DATA_W-1:0] wd,
                         output logic [DATA_W-1:0] rdat, output logic oe, output logic ok);
      int n;
      n = 0;
      ok = 1'b1;
      @(posedge mclk);
      port_sel <= sel;
      read_sel <= rdn;
      dal_in <= rdn ? ~dal_in : wd;
      cs_n <= 1'b0;
      das_n <= 1'b0;
      do begin
         @(posedge mclk);
         n++;
      end while (ready_n !== 1'b0 && n < 20);
      rdat = dal_out;
      oe = dal_oe_n;
      ok = (ready_n === 1'b0);
      cs_n <= 1'b1;
      das_n <= 1'b1;
      dal_in <= ~dal_in;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ready_n !== 1'b1 && n < 20);
      if (ready_n !== 1'b1) ok = 1'b0;
   endtask
endmodule

/* tb/ethernet_controller_csr_bank_tb_top.sv */
module ethernet_controller_csr_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import csr_bank_pkg::*;
   typedef struct packed {
      logic [1:0] idx;
      logic [15:0] wdata;
      logic [15:0] rdata;
   } row_s;
   localparam int POLL = 400;
   logic mclk, resetn, cs_n, read_sel, das_n, port_sel, dal_oe_n, ready_n, summary_interrupt_flag_n;
   logic [15:0] dal_in, dal_out, mode_word, mem_word_in, mem_word_out, rd;
   logic mem_word_is_fifo, strobe_req, upper_byte_mask, lower_byte_mask, hold_req;
   logic grant_chain_output, byte_sel, bus_request_pin, address_strobe_pin, oe, ok;
   logic setup_req, run_enable, rx_enable, tx_enable, scan_ring, accept_all_addresses_bit, halted;
   logic [2:0] redefined_pins;
   logic [23:0] param_block_pointer;
   options_s options;
   events_s evt;
   int n_fail = 0;
   int compares = 0;
   int n_scan = 0;
   int k;
   int ev_pos [5] = '{4, 3, 8, 6, 5};
   int flag_pos [5] = '{10, 9, 14, 12, 11};
   row_s rows [4];

   ethernet_controller_csr_bank #(.POLL_CYC(POLL)) i_ethernet_controller_csr_bank (
      .mclk, .resetn, .cs_n, .read_sel, .das_n, .port_sel, .dal_in, .dal_out, .dal_oe_n,
      .ready_n, .summary_interrupt_flag_n, .evt, .mode_word, .mem_word_in, .mem_word_is_fifo, .mem_word_out,
      .strobe_req, .upper_byte_mask, .lower_byte_mask, .hold_req, .grant_chain_output,
      .byte_sel, .bus_request_pin, .address_strobe_pin, .redefined_pins,
      .param_block_pointer, .options, .setup_req, .run_enable, .rx_enable, .tx_enable,
      .scan_ring, .accept_all_addresses_bit, .halted);
   host_bus_model i_host_bus_model (.mclk, .ready_n, .dal_out, .dal_oe_n, .cs_n,
      .read_sel, .das_n, .port_sel, .dal_in);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      resetn = 1'b0;
      evt = '0;
      {mode_word, mem_word_in, mem_word_is_fifo, strobe_req} = '0;
      {upper_byte_mask, lower_byte_mask, hold_req} = '0;
      {grant_chain_output, byte_sel, bus_request_pin} = '0;
   end
   always @(posedge mclk) if (scan_ring === 1'b1) n_scan <= n_scan + 1;

   task automatic report_and_stop();
      if (n_fail == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      chk({23'h000000, got}, {23'h000000, exp}, what);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic acc(input logic sel, input logic rdn, input logic [15:0] d);
      i_host_bus_model.access(sel, rdn, d, rd, oe, ok);
      chk1(ok, 1'b1, "handshake");
   endtask
   task automatic csr_wr(input logic [1:0] idx, input logic [15:0] d);
      acc(1'b1, 1'b0, {14'h0000, idx});
      acc(1'b0, 1'b0, d);
   endtask
   task automatic csr_rd(input logic [1:0] idx);
      acc(1'b1, 1'b0, {14'h0000, idx});
      acc(1'b0, 1'b1, 16'h0000);
   endtask
   task automatic pulse(input int p);
      @(posedge mclk);
      evt <= events_s'(9'h001 << p);
      @(posedge mclk);
      evt <= '0;
      cyc(2);
   endtask
   task automatic do_reset();
      @(posedge mclk);
      resetn <= 1'b0;
      cyc(3);
      resetn <= 1'b1;
      cyc(3);
   endtask

   initial begin
      // Long enough for the whole sequence including two poll spans
      cyc(20000);
      n_fail++;
      report_and_stop();
   end

   initial begin
      rows = '{'{IDX_PTR_LOW, 16'hABCD, 16'hABCC}, '{IDX_PTR_HIGH, 16'h5A3C, 16'h003C},
               '{IDX_OPTIONS, 16'hFFFF, 16'h0007}, '{IDX_PTR_LOW, 16'h1235, 16'h1234}};
      do_reset();
      chk1(halted, 1'b1, "halted");
      chk1(summary_interrupt_flag_n, 1'b1, "summary_interrupt_flag");
      csr_rd(IDX_COMMAND);
      chk(24'(rd), 24'h000004, "cmd");
      foreach (rows[i]) begin
         csr_wr(rows[i].idx, rows[i].wdata);
         csr_rd(rows[i].idx);
         chk(24'(rd), 24'(rows[i].rdata), "row");
      end
      chk(param_block_pointer, 24'h3C1234, "ptr");
      csr_wr(IDX_COMMAND, 16'h0007);
      csr_rd(IDX_COMMAND);
      chk(24'(rd), 24'h000004, "triple");
      chk(24'(options), 24'h000000, "opt");
      csr_wr(IDX_OPTIONS, 16'h0007);
      @(posedge mclk);
      mode_word <= 16'h8000;
      csr_wr(IDX_COMMAND, 16'h0003);
      chk1(setup_req, 1'b1, "setup");
      chk1(run_enable, 1'b0, "run");
      pulse(2);
      csr_rd(IDX_COMMAND);
      chk(24'(rd), 24'h0001B2, "cmd");
      chk1(accept_all_addresses_bit, 1'b1, "accept");
      chk1(run_enable & rx_enable & tx_enable, 1'b1, "run");
      chk1(summary_interrupt_flag_n, 1'b1, "summary_interrupt_flag");
      csr_wr(IDX_OPTIONS, 16'h0000);
      chk(24'(options), 24'h000007, "opt");
      csr_rd(IDX_OPTIONS);
      chk1(oe, 1'b1, "oe");
      @(posedge mclk);
      {mem_word_in, mem_word_is_fifo, strobe_req} <= {16'h1234, 2'b11};
      {grant_chain_output, byte_sel, bus_request_pin, lower_byte_mask} <= 4'hB;
      cyc(3);
      chk(24'(mem_word_out), 24'h003412, "swap");
      chk1(address_strobe_pin, 1'b0, "strobe");
      chk(24'(redefined_pins), 24'h000005, "pins");
      mem_word_is_fifo <= 1'b0;
      cyc(3);
      chk(24'(mem_word_out), 24'h001234, "noswap");
      csr_wr(IDX_COMMAND, 16'h0140);
      cyc(2);
      chk1(summary_interrupt_flag_n, 1'b1, "summary_interrupt_flag");
      pulse(1);
      csr_rd(IDX_COMMAND);
      chk(24'(rd), 24'h000062, "cmd");
      for (int i = 0; i < 5; i++) begin
         pulse(ev_pos[i]);
         chk1(summary_interrupt_flag_n, 1'b0, "summary_interrupt_flag");
         csr_rd(IDX_COMMAND);
         chk1(rd[flag_pos[i]] & rd[B_SUMMARY], 1'b1, "flag");
         csr_wr(IDX_COMMAND, 16'h0040 | (16'h0001 << flag_pos[i]));
         cyc(2);
         chk1(summary_interrupt_flag_n, 1'b1, "summary_interrupt_flag");
      end
      csr_rd(IDX_COMMAND);
      chk(24'(rd), 24'h000042, "cmd");
      // Underflow and memory error left the engines off: set up again before polling
      csr_wr(IDX_COMMAND, 16'h0041);
      pulse(2);
      csr_wr(IDX_COMMAND, 16'h0140);
      chk1(tx_enable & rx_enable, 1'b1, "reinit");
      k = n_scan;
      csr_wr(IDX_COMMAND, 16'h0048);
      chk1(n_scan > k, 1'b1, "demand");
      pulse(0);
      csr_rd(IDX_COMMAND);
      chk1(rd[B_DEMAND], 1'b0, "demand");
      k = n_scan;
      cyc(POLL + 10);
      chk1(n_scan > k, 1'b1, "poll");
      pulse(4);
      chk1(summary_interrupt_flag_n, 1'b0, "summary_interrupt_flag");
      csr_wr(IDX_COMMAND, 16'h0004);
      cyc(2);
      chk1(summary_interrupt_flag_n, 1'b1, "summary_interrupt_flag");
      chk1(run_enable, 1'b0, "run");
      csr_rd(IDX_COMMAND);
      chk(24'(rd), 24'h000004, "halt");
      chk(24'(options), 24'h000000, "opt");
      k = n_scan;
      cyc(POLL + 10);
      chk1(n_scan == k, 1'b1, "quiet");
      acc(1'b1, 1'b0, 16'h0002);
      do_reset();
      acc(1'b1, 1'b1, 16'h0000);
      chk(24'(rd), 24'h000000, "index");
      chk(param_block_pointer, 24'h3C1234, "ptr");
      csr_rd(IDX_COMMAND);
      chk(24'(rd), 24'h000004, "cmd");
      report_and_stop();
   end
endmodule
